/* File: dbg_pkg.sv */
// shared constants and types for the bus compare and trace debugger
`default_nettype none
package dbg_pkg;
	// ==========================================
	// register indices
	localparam logic [3:0] IDX_CAH = 4'h0;
	localparam logic [3:0] IDX_CAL = 4'h1;
	localparam logic [3:0] IDX_CBH = 4'h2;
	localparam logic [3:0] IDX_CBL = 4'h3;
	localparam logic [3:0] IDX_FH  = 4'h4;
	localparam logic [3:0] IDX_FL  = 4'h5;
	localparam logic [3:0] IDX_CTL = 4'h6;
	localparam logic [3:0] IDX_TRG = 4'h7;
	localparam logic [3:0] IDX_STS = 4'h8;
	// ==========================================
	// field positions
	localparam int B_ON    = 7;
	localparam int B_ARM   = 6;
	localparam int B_TAG   = 5;
	localparam int B_BRK   = 4;
	localparam int B_ADIR    = 3;
	localparam int B_ADIR_EN = 2;
	localparam int B_BDIR    = 1;
	localparam int B_BDIR_EN = 0;
	localparam int B_TSEL  = 7;
	localparam int B_BEGIN = 6;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] TRG_MASK = 8'hcf;
	// ==========================================
	// trace memory and trigger modes
	localparam int FIFO_AW = 3;
	localparam logic [3:0] FIFO_LAST = 4'h7;
	localparam logic [3:0] FIFO_FULL = 4'h8;
	localparam logic [3:0] M_A     = 4'h0;
	localparam logic [3:0] M_AORB  = 4'h1;
	localparam logic [3:0] M_ATHB  = 4'h2;
	localparam logic [3:0] M_EVB   = 4'h3;
	localparam logic [3:0] M_AEVB  = 4'h4;
	localparam logic [3:0] M_ANDD  = 4'h5;
	localparam logic [3:0] M_ANOTD = 4'h6;
	localparam logic [3:0] M_IN    = 4'h7;
	localparam logic [3:0] M_OUT   = 4'h8;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
		logic        rd;
		logic        opfetch;
		logic        valid;
	} bus_cycle_s;
	typedef enum logic [1:0] {RUN_IDLE, RUN_END, RUN_WAIT, RUN_FILL} run_e;
endpackage
`default_nettype wire

/* File: addr_cmp.sv */
// one address comparator with read/write qualifier
`default_nettype none
module addr_cmp (
	input  wire logic              [15:0] value,
	input  wire dbg_pkg::bus_cycle_s      cyc,
	input  wire logic                     dir_check,
	input  wire logic                     dir_value,
	output logic                          match,
	output logic                          below,
	output logic                          above
);
	// ==========================================
	// compare
	always_comb
	begin
		match = cyc.valid && (cyc.addr == value) && (!dir_check || (cyc.rd == dir_value));
		below = cyc.addr < value;
		above = cyc.addr > value;
	end
endmodule
`default_nettype wire

/* File: trace_mem.sv */
// eight word trace memory with registered read data
`default_nettype none
module trace_mem (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        we,
	input  wire logic [2:0]  waddr,
	input  wire logic [15:0] wdata,
	input  wire logic [2:0]  raddr,
	output logic      [15:0] rdata
);
	logic [15:0] mem [8];
	// ==========================================
	// storage
	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdata <= 16'h0000;
		end
		else
		begin
			rdata <= mem[raddr];
		end
	end
endmodule
`default_nettype wire

/* File: bus_compare_trace_debugger.sv */
// debug comparators, trace memory and break request logic
//
// Behaviour
// R1: comparator bytes reset to zero, always readable, writes ignored while armed.
// R2: nine byte registers: two comparators, trace word, three control bytes.
// R3: trace high byte is read only; reads zero in event-only modes.
// R4: reading trace high byte does not move the read pointer.
// R5: reading trace low byte returns low half then advances; writes ignored.
// R6: event-only modes store only a data byte in the low half.
// R7: reader fetches high byte before low byte.
// R8: low byte reads do not advance while armed; read after the run.
// R9: unarmed low read stores last opcode address into the slot just read.
// R10: host discards first eight unarmed reads to prime profiling.
// R11: control register readable and writable at any time.
// R12: bit 7 enables module; setting it refused while secure.
// R13: bit 6 arms the run; run end or clearing bits 6/7 stops it.
// R14: bit 5 selects tag or force break type.
// R15: bit 4 lets trigger events request a processor break.
// R16: end trace breaks on trigger, begin trace breaks when memory fills.
// R17: bits 2 and 3 qualify comparator A by read or write.
// R18: bits 0 and 1 qualify comparator B by read or write.
// R19: run ends on full memory in begin trace, trigger in end trace.
// R20: armed flag mirrors arm bit and clears when the run ends.
// R21: comparators check every bus cycle, honouring the direction qualifier.
// R22: memory holds eight 16-bit words, emptied when each run starts.
`default_nettype none
module bus_compare_trace_debugger (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                secure,
	input  wire dbg_pkg::bus_cycle_s cyc,
	input  wire logic          [3:0] reg_sel,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	input  wire logic          [7:0] reg_wdata,
	output logic               [7:0] reg_rdata,
	output logic                     brk_req,
	output logic                     brk_tag
);
	logic [15:0]   cmp_a_r;
	logic [15:0]   cmp_b_r;
	logic [7:0]    ctl_r;
	logic [7:0]    trg_r;
	logic          af_r;
	logic          bf_r;
	logic          seen_a_r;
	logic [3:0]    cnt_r;
	logic [2:0]    wr_ptr_r;
	logic [2:0]    rd_ptr_r;
	logic [15:0]   last_op_r;
	dbg_pkg::run_e st_r;
	logic          armed;
	logic          on_nxt;
	logic          arm_start;
	logic          ctl_wr;
	logic          event_only;
	logic          ma;
	logic          mb;
	logic          a_below;
	logic          b_above;
	logic          raw_trig;
	logic          trig;
	logic          store;
	logic          run_end;
	logic          lo_rd;
	logic          mem_we;
	logic [2:0]    mem_waddr;
	logic [15:0]   mem_wdata;
	logic [15:0]   mem_rdata;
	logic [2:0]    wr_ptr_nxt;

	// ==========================================
	// helpers
	function automatic logic [15:0] set_byte(input logic [15:0] w, input logic hi,
		input logic [7:0] b);
		set_byte = hi ? {b, w[7:0]} : {w[15:8], b};
	endfunction

	// ==========================================
	// comparators and memory
	// R21: compare every cycle
	// R17: a direction qualifier
	addr_cmp u_cmp_a (
		.value     (cmp_a_r),
		.cyc       (cyc),
		.dir_check (ctl_r[dbg_pkg::B_ADIR_EN]),
		.dir_value (ctl_r[dbg_pkg::B_ADIR]),
		.match     (ma),
		.below     (a_below),
		.above     ()
	);
	// R18: b direction qualifier
	addr_cmp u_cmp_b (
		.value     (cmp_b_r),
		.cyc       (cyc),
		.dir_check (ctl_r[dbg_pkg::B_BDIR_EN]),
		.dir_value (ctl_r[dbg_pkg::B_BDIR]),
		.match     (mb),
		.below     (),
		.above     (b_above)
	);
	// R22: eight word store
	trace_mem u_mem (
		.clk   (clk),
		.rst   (rst),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (mem_wdata),
		.raddr (rd_ptr_r),
		.rdata (mem_rdata)
	);

	// ==========================================
	// control decode
	always_comb
	begin
		armed = ctl_r[dbg_pkg::B_ARM];
		ctl_wr = reg_wr && (reg_sel == dbg_pkg::IDX_CTL);
		// R12: no enabling while secure
		on_nxt = reg_wdata[dbg_pkg::B_ON] && (!secure || ctl_r[dbg_pkg::B_ON]);
		// re-arm on the run-end edge starts afresh instead of sticking armed
		arm_start = ctl_wr && reg_wdata[dbg_pkg::B_ARM] && on_nxt && (!armed || run_end);
		event_only = (trg_r[3:0] == dbg_pkg::M_EVB) || (trg_r[3:0] == dbg_pkg::M_AEVB);
		lo_rd = reg_rd && (reg_sel == dbg_pkg::IDX_FL);
	end

	// ==========================================
	// trigger
	always_comb
	begin
		case (trg_r[3:0])
			dbg_pkg::M_A:     raw_trig = ma;
			dbg_pkg::M_AORB:  raw_trig = ma || mb;
			dbg_pkg::M_ATHB:  raw_trig = mb && seen_a_r;
			dbg_pkg::M_EVB:   raw_trig = mb;
			dbg_pkg::M_AEVB:  raw_trig = mb && seen_a_r;
			dbg_pkg::M_ANDD:  raw_trig = ma && (cyc.data == cmp_b_r[7:0]);
			dbg_pkg::M_ANOTD: raw_trig = ma && (cyc.data != cmp_b_r[7:0]);
			dbg_pkg::M_IN:    raw_trig = cyc.valid && !a_below && !b_above;
			dbg_pkg::M_OUT:   raw_trig = cyc.valid && (a_below || b_above);
			default:          raw_trig = 1'b0;
		endcase
		// opcode qualification approximated by the fetch strobe
		trig = armed && raw_trig && (!trg_r[dbg_pkg::B_TSEL] || cyc.opfetch);
	end

	// ==========================================
	// storage and run end
	always_comb
	begin
		store = 1'b0;
		unique case (st_r)
			dbg_pkg::RUN_IDLE: store = 1'b0;
			dbg_pkg::RUN_WAIT: store = 1'b0;
			dbg_pkg::RUN_END:  store = armed && cyc.valid && cyc.opfetch;
			dbg_pkg::RUN_FILL: store = armed && (event_only ? trig : cyc.valid && cyc.opfetch);
		endcase
		// R19: end on trigger or on full
		run_end = armed && (((st_r == dbg_pkg::RUN_END) && trig) ||
			((st_r == dbg_pkg::RUN_FILL) && store && (cnt_r == dbg_pkg::FIFO_LAST)));
		wr_ptr_nxt = store ? 3'(wr_ptr_r + 3'h1) : wr_ptr_r;
		// R9: unarmed read refills slot
		mem_we = store || (lo_rd && !armed);
		mem_waddr = armed ? wr_ptr_r : rd_ptr_r;
		// R6: data byte only
		mem_wdata = !armed ? last_op_r : event_only ? {8'h00, cyc.data} : cyc.addr;
	end

	// ==========================================
	// comparator registers
	// R1: locked while armed
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cmp_a_r <= {dbg_pkg::RST_BYTE, dbg_pkg::RST_BYTE};
			cmp_b_r <= {dbg_pkg::RST_BYTE, dbg_pkg::RST_BYTE};
		end
		else if (reg_wr && !armed)
		begin
			if (reg_sel == dbg_pkg::IDX_CAH || reg_sel == dbg_pkg::IDX_CAL)
			begin
				cmp_a_r <= set_byte(cmp_a_r, reg_sel == dbg_pkg::IDX_CAH, reg_wdata);
			end
			if (reg_sel == dbg_pkg::IDX_CBH || reg_sel == dbg_pkg::IDX_CBL)
			begin
				cmp_b_r <= set_byte(cmp_b_r, reg_sel == dbg_pkg::IDX_CBH, reg_wdata);
			end
		end
	end

	// ==========================================
	// control and trigger registers
	// R11: control always writable; trigger register locked while armed
	// R13: arm set by write, cleared by run end
	// R20: arm bit doubles as armed flag
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctl_r <= dbg_pkg::RST_BYTE;
		end
		else if (ctl_wr)
		begin
			ctl_r <= {on_nxt, reg_wdata[dbg_pkg::B_ARM] && on_nxt, reg_wdata[5:0]};
		end
		else if (run_end)
		begin
			ctl_r[dbg_pkg::B_ARM] <= 1'b0;
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			trg_r <= dbg_pkg::RST_BYTE;
		end
		else if (reg_wr && !armed && reg_sel == dbg_pkg::IDX_TRG)
		begin
			trg_r <= reg_wdata & dbg_pkg::TRG_MASK;
		end
	end

	// ==========================================
	// run sequencing
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_r <= dbg_pkg::RUN_IDLE;
		end
		else if (arm_start)
		begin
			// event-only runs are always begin traces
			if (event_only)
			begin
				st_r <= dbg_pkg::RUN_FILL;
			end
			else
			begin
				st_r <= trg_r[dbg_pkg::B_BEGIN] ? dbg_pkg::RUN_WAIT : dbg_pkg::RUN_END;
			end
		end
		else if (run_end || !armed)
		begin
			st_r <= dbg_pkg::RUN_IDLE;
		end
		else if (st_r == dbg_pkg::RUN_WAIT && trig)
		begin
			st_r <= dbg_pkg::RUN_FILL;
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst || arm_start)
		begin
			af_r <= 1'b0;
			bf_r <= 1'b0;
			seen_a_r <= 1'b0;
		end
		else if (armed)
		begin
			af_r <= af_r || ma;
			bf_r <= bf_r || mb;
			seen_a_r <= seen_a_r || ma;
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			last_op_r <= 16'h0000;
		end
		else if (cyc.valid && cyc.opfetch)
		begin
			last_op_r <= cyc.addr;
		end
	end

	// ==========================================
	// trace pointers
	// R22: emptied at run start
	always_ff @(posedge clk)
	begin
		if (rst || arm_start)
		begin
			cnt_r <= 4'h0;
			wr_ptr_r <= 3'h0;
		end
		else if (store)
		begin
			wr_ptr_r <= wr_ptr_nxt;
			if (cnt_r != dbg_pkg::FIFO_FULL)
			begin
				cnt_r <= 4'(cnt_r + 4'h1);
			end
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst || arm_start)
		begin
			rd_ptr_r <= 3'h0;
		end
		else if (run_end)
		begin
			// oldest word first once the circle has wrapped
			rd_ptr_r <= (cnt_r == dbg_pkg::FIFO_FULL) ? wr_ptr_nxt : 3'h0;
		end
		// R5: low read advances
		// R8: frozen while armed
		else if (lo_rd && !armed)
		begin
			rd_ptr_r <= 3'(rd_ptr_r + 3'h1);
		end
	end

	// ==========================================
	// read data and break request
	// R2: nine byte map
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reg_rdata <= 8'h00;
		end
		else if (reg_rd)
		begin
			case (reg_sel)
				dbg_pkg::IDX_CAH: reg_rdata <= cmp_a_r[15:8];
				dbg_pkg::IDX_CAL: reg_rdata <= cmp_a_r[7:0];
				dbg_pkg::IDX_CBH: reg_rdata <= cmp_b_r[15:8];
				dbg_pkg::IDX_CBL: reg_rdata <= cmp_b_r[7:0];
				// R3: zero in event-only modes
				// R4: no pointer move here
				dbg_pkg::IDX_FH:  reg_rdata <= event_only ? 8'h00 : mem_rdata[15:8];
				dbg_pkg::IDX_FL:  reg_rdata <= mem_rdata[7:0];
				dbg_pkg::IDX_CTL: reg_rdata <= ctl_r;
				dbg_pkg::IDX_TRG: reg_rdata <= trg_r;
				dbg_pkg::IDX_STS: reg_rdata <= {af_r, bf_r, armed, 1'b0, cnt_r};
				default:          reg_rdata <= 8'h00;
			endcase
		end
	end
	// R15: break only when enabled
	// R16: registered one cycle after run end
	// R14: type latched with request
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			brk_req <= 1'b0;
			brk_tag <= 1'b0;
		end
		else
		begin
			brk_req <= run_end && ctl_r[dbg_pkg::B_BRK];
			brk_tag <= run_end && ctl_r[dbg_pkg::B_BRK] && ctl_r[dbg_pkg::B_TAG];
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence lo_rd_s;
		reg_rd && reg_sel == dbg_pkg::IDX_FL && !reg_wr;
	endsequence
	sequence quiet_s;
		!run_end && !arm_start;
	endsequence
	cmp_lock_a: assert property (armed |=> $stable(cmp_a_r) && $stable(cmp_b_r)) // R1
		else $error("comparator changed while armed");
	hi_zero_a: assert property (reg_rd && reg_sel == dbg_pkg::IDX_FH && event_only // R3
		|=> reg_rdata == 8'h00) else $error("high byte not zero");
	hi_hold_a: assert property (reg_rd && reg_sel == dbg_pkg::IDX_FH ##0 quiet_s // R4
		|=> $stable(rd_ptr_r)) else $error("high read moved pointer");
	lo_step_a: assert property (lo_rd_s ##0 quiet_s ##0 !armed // R5
		|=> rd_ptr_r == 3'($past(rd_ptr_r) + 3'h1)) else $error("low read did not advance");
	armed_hold_a: assert property (lo_rd_s ##0 quiet_s ##0 armed // R8
		|=> $stable(rd_ptr_r)) else $error("armed read advanced");
	profile_a: assert property (lo_rd_s ##0 !armed |-> mem_we && mem_wdata == last_op_r) // R9
		else $error("profile sample not stored");
	secure_a: assert property (secure && !ctl_r[dbg_pkg::B_ON] |=> !ctl_r[dbg_pkg::B_ON]) // R12
		else $error("enabled while secure");
	run_stop_a: assert property (run_end && !ctl_wr // R13
		|=> !armed ##1 (!armed || $past(ctl_wr)))
		else $error("arm not cleared at run end");
	brk_type_a: assert property (run_end |=> brk_req == $past(ctl_r[dbg_pkg::B_BRK]) // R14
		&& brk_tag == $past(ctl_r[dbg_pkg::B_BRK] && ctl_r[dbg_pkg::B_TAG]))
		else $error("break request wrong");
	brk_off_a: assert property (!run_end |=> !brk_req) // R15
		else $error("break without run end");
	dir_a_a: assert property (ctl_r[dbg_pkg::B_ADIR_EN] // R17
		&& cyc.rd != ctl_r[dbg_pkg::B_ADIR] |-> !ma)
		else $error("comparator a ignored direction");
	dir_b_a: assert property (ctl_r[dbg_pkg::B_BDIR_EN] // R18
		&& cyc.rd != ctl_r[dbg_pkg::B_BDIR] |-> !mb)
		else $error("comparator b ignored direction");
	fill_end_a: assert property (armed && st_r == dbg_pkg::RUN_FILL && store // R19
		&& cnt_r == dbg_pkg::FIFO_LAST |-> run_end) else $error("full run not ended");
	empty_a: assert property (arm_start |=> cnt_r == 4'h0 && armed) // R22
		else $error("run start not emptied");
endmodule
`default_nettype wire

/* File: core_bus_model.sv */
// processor core model: issues bus cycles and takes break requests
`default_nettype none
module core_bus_model (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                brk_req,
	input  wire logic                brk_tag,
	output var  dbg_pkg::bus_cycle_s cyc
);
	timeunit 1ns;
	timeprecision 1ns;
	int   brk_count;
	logic last_tag = 1'b0;
	initial cyc = '0;
	// ==========================================
	// break input
	// counted per pulse
	always @(posedge clk)
		if (rst)
			brk_count <= 0;
		else if (brk_req === 1'b1)
		begin
			brk_count <= brk_count + 1;
			last_tag  <= brk_tag;
		end
	// ==========================================
	// bus cycles
	// idle bus shows inverted values, so a stale address cannot match by luck
	task automatic bus(input logic [15:0] a, input logic r, input logic op);
		@(posedge clk);
		cyc <= '{addr: a, data: a[7:0], rd: r, opfetch: op, valid: 1'b1};
		@(posedge clk);
		cyc <= '{addr: ~a, data: ~a[7:0], rd: ~r, opfetch: 1'b0, valid: 1'b0};
	endtask
endmodule
`default_nettype wire

/* File: tb_bus_compare_trace_debugger.sv */
// self-checking bench for the bus compare and trace debugger
`default_nettype none
module tb_bus_compare_trace_debugger;
	timeunit 1ns;
	timeprecision 1ns;
	logic                clk       = 1'b0;
	logic                rst       = 1'b1;
	logic                secure    = 1'b0;
	logic                reg_wr    = 1'b0;
	logic                reg_rd    = 1'b0;
	logic          [3:0] reg_sel   = 4'h0;
	logic          [7:0] reg_wdata = 8'h00;
	logic          [7:0] reg_rdata;
	logic          [7:0] rv;
	logic          [7:0] ctl;
	logic          [7:0] qual [4] = '{8'h04, 8'h0c, 8'h01, 8'h03};
	logic          [3:0] idx [6]  = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h9};
	logic          [7:0] trg_mode [5] = '{8'h02, 8'h07, 8'h08, 8'h06, 8'h80};
	logic         [15:0] no_addr [5]  = '{16'h5678, 16'h0100, 16'h3000, 16'h0100, 16'h1234};
	logic         [15:0] hit_addr [5] = '{16'h5678, 16'h3000, 16'h0100, 16'h1234, 16'h1234};
	logic         [15:0] w;
	logic         [15:0] a;
	logic                brk_req;
	logic                brk_tag;
	dbg_pkg::bus_cycle_s cyc;
	int                  miscompares     = 0;
	int                  samples_checked = 0;
	int                  cycles          = 0;
	int                  n0;
	always #20 clk = ~clk;
	bus_compare_trace_debugger dut_u (.clk(clk), .rst(rst), .secure(secure), .cyc(cyc),
		.reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .brk_req(brk_req), .brk_tag(brk_tag));
	core_bus_model core_u (.clk(clk), .rst(rst), .brk_req(brk_req), .brk_tag(brk_tag),
		.cyc(cyc));
	// ==========================================
	// register access and compare
	task automatic wr(input logic [3:0] s, input logic [7:0] d);
		@(posedge clk);
		reg_sel   <= s;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// one idle cycle between reads keeps trace reads at the allowed spacing
	task automatic rd(input logic [3:0] s);
		@(posedge clk);
		reg_sel <= s;
		reg_rd  <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [3:0] s, input logic [7:0] e);
		rd(s);
		chk({8'h00, rv}, {8'h00, e});
	endtask
	task automatic brk_delta(input int e);
		repeat (3) @(posedge clk);
		chk(16'(core_u.brk_count - n0), 16'(e));
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==========================================
	// hang guard, run needs about 475 cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			miscompares++;
			report_and_stop();
		end
	end
	// ==========================================
	// tests
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++)
			rdchk(idx[i], 8'h00);
		for (int i = 0; i < 4; i++)
			wr(i[3:0], 8'h12 + 8'(i) * 8'h22);
		for (int i = 0; i < 4; i++)
			rdchk(i[3:0], 8'h12 + 8'(i) * 8'h22);
		secure <= 1'b1;
		wr(4'h6, 8'hc0);
		rdchk(4'h6, 8'h00);
		secure <= 1'b0;
		wr(4'h6, 8'h80);
		rdchk(4'h6, 8'h80);
		$display("access test done");
		// direction qualifiers, both comparators, both break types
		for (int k = 0; k < 4; k++)
		begin
			a   = k[1] ? 16'h5678 : 16'h1234;
			ctl = 8'hd0 | qual[k] | (k[0] ? 8'h20 : 8'h00);
			wr(4'h7, {7'h00, k[1]});
			wr(4'h6, ctl);
			rd(4'h8);
			chk({15'h0, rv[5]}, 16'h1);
			wr(4'h0, 8'hee);
			rdchk(4'h0, 8'h12);
			n0 = core_u.brk_count;
			core_u.bus(a, ~k[0], 1'b0);
			brk_delta(0);
			core_u.bus(a, k[0], 1'b0);
			brk_delta(1);
			chk({15'h0, core_u.last_tag}, {15'h0, k[0]});
			rdchk(4'h6, ctl & 8'hbf);
			rd(4'h8);
			chk({15'h0, rv[5]}, 16'h0);
		end
		$display("qualifier test done");
		for (int k = 0; k < 2; k++)
		begin
			wr(4'h6, 8'hc0);
			wr(4'h6, k[0] ? 8'h00 : 8'h80);
			rd(4'h8);
			chk({15'h0, rv[5]}, 16'h0);
		end
		$display("manual stop test done");
		// begin trace fills eight words after the trigger
		wr(4'h6, 8'h80);
		wr(4'h7, 8'h40);
		wr(4'h6, 8'hd0);
		n0 = core_u.brk_count;
		core_u.bus(16'h0100, 1'b1, 1'b1);
		core_u.bus(16'h1234, 1'b1, 1'b1);
		for (int i = 0; i < 8; i++)
			core_u.bus(16'h2000 + 16'(i), 1'b1, 1'b1);
		brk_delta(1);
		rd(4'h8);
		chk({12'h0, rv[3:0]}, 16'h8);
		for (int i = 0; i < 8; i++)
		begin
			rd(4'h4);
			w[15:8] = rv;
			rd(4'h4);
			chk({8'h00, rv}, {8'h00, w[15:8]});
			rd(4'h5);
			w[7:0] = rv;
			// trigger cycle opens the window but is not stored itself
			chk(w, 16'h2000 + 16'(i));
		end
		$display("begin trace test done");
		// profiling while unarmed, first eight reads only prime the slots
		wr(4'h6, 8'h80);
		for (int i = 0; i < 16; i++)
		begin
			core_u.bus(16'h3000 + 16'(i), 1'b1, 1'b1);
			rd(4'h4);
			w[15:8] = rv;
			rd(4'h5);
			w[7:0] = rv;
			if (i >= 8)
				chk(w, 16'h3000 + 16'(i - 8));
		end
		$display("profiling test done");
		// a then b, inside, outside and a-not-data modes as end traces, opcode qualify last
		for (int k = 0; k < 5; k++)
		begin
			wr(4'h7, trg_mode[k]);
			wr(4'h6, 8'hd0);
			n0 = core_u.brk_count;
			core_u.bus(no_addr[k], 1'b1, ~trg_mode[k][7]);
			brk_delta(0);
			if (k == 0)
				core_u.bus(16'h1234, 1'b1, 1'b1);
			core_u.bus(hit_addr[k], 1'b1, 1'b1);
			brk_delta(1);
			if (k == 0)
			begin
				rd(4'h8);
				chk({14'h0, rv[7:6]}, 16'h3);
			end
		end
		// trigger with breaks off still ends the run
		wr(4'h7, 8'h00);
		wr(4'h6, 8'hc0);
		n0 = core_u.brk_count;
		core_u.bus(16'h1234, 1'b1, 1'b1);
		brk_delta(0);
		rd(4'h8);
		chk({15'h0, rv[5]}, 16'h0);
		$display("trigger mode test done");
		wr(4'h7, 8'h33);
		rdchk(4'h7, 8'h03);
		wr(4'h4, 8'hff);
		rdchk(4'h4, 8'h00);
		// event-only run stores the data byte of eight b accesses
		wr(4'h6, 8'hd0);
		n0 = core_u.brk_count;
		for (int i = 0; i < 8; i++)
			core_u.bus(16'h5678, 1'b1, 1'b1);
		brk_delta(1);
		for (int i = 0; i < 8; i++)
		begin
			rdchk(4'h4, 8'h00);
			rdchk(4'h5, 8'h78);
		end
		$display("event mode test done");
		report_and_stop();
	end
endmodule
`default_nettype wire
